// ---- core/tws_slave_port.sv ----
// two-wire serial slave port with register set and alert pin of a sensor
`timescale 1ns/1ps
`default_nettype none
`include "tws_cfg.svh"
module tws_slave_port
  import tws_pkg::*;
#(
  parameter int FIFO_DEPTH = `TWS_FIFO_DEPTH
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_o,
  output logic             o_sda_oe,
  input  wire logic        i_addr_select_hi,
  input  wire logic        i_addr_select_mid,
  input  wire logic        i_addr_select_lo,
  input  wire logic [15:0] i_temperature,
  input  wire logic        i_alert_trip,
  input  wire logic        i_write_hold,
  output logic             o_alert_output_o,
  output logic             o_alert_output_oe,
  output logic [7:0]       o_config,
  output logic [15:0]      o_setpoint,
  output logic [15:0]      o_hysteresis_threshold,
  output logic             o_reg_write,
  output logic [1:0]       o_reg_write_sel,
  output logic             o_reg_read
);

  // ========================================================================
  // elaboration check on buffer depth
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("tws_slave_port needs a write buffer of at least two words");
  end

  // ========================================================================
  // helper functions

  // prefix and select pins must both agree
  function automatic logic addr_match(input logic [7:0] addr_byte,
                                      input logic [2:0] pins);
    // R9 prefix check
    addr_match = (addr_byte[7:4] == `TWS_ADDR_PREFIX) &&
    // R10 select pins match
                 (addr_byte[3:1] == pins);
  endfunction : addr_match

  // byte of the selected register to shift out
  function automatic logic [7:0] reg_byte(input tws_sel_type  sel,
                                          input logic         lo_half,
                                          input logic [15:0]  temp,
                                          input logic [7:0]   cfg,
                                          input logic [15:0]  hyst,
                                          input logic [15:0]  setp);
    logic [15:0] word;
    word = 16'h0000;
    // R17 selector decode
    case (sel)
      `TWS_SEL_TEMP:     word = temp;
      `TWS_SEL_HYST:     word = hyst;
      `TWS_SEL_SETPOINT: word = setp;
      default:           word = 16'h0000;
    endcase
    // R18 config reads as one byte
    if (sel == `TWS_SEL_CONFIG) reg_byte = cfg;
    else if (lo_half)           reg_byte = word[7:0];
    else                        reg_byte = word[15:8];
  endfunction : reg_byte

  // ========================================================================
  // pin synchronisers: three stages, a rise counts once stages two and three
  // are both high, a fall as soon as stage two goes low, so only single-sample high glitches are rejected

  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic [4:0] pin_s3;
  logic [4:0] pin_f;
  logic       scl_q;
  logic       sda_q;
  logic       scl_f;
  logic       sda_f;
  logic [2:0] sel_pins;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_s1 <= `TWS_PIN_IDLE;
      pin_s2 <= `TWS_PIN_IDLE;
      pin_s3 <= `TWS_PIN_IDLE;
      pin_f  <= `TWS_PIN_IDLE;
    end else begin
      pin_s1 <= {i_scl, i_sda, i_addr_select_hi, i_addr_select_mid, i_addr_select_lo};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= (pin_s2 & pin_s3) | (pin_f & ~(pin_s2 ^ pin_s3));
    end
  end

  assign scl_f    = pin_f[4];
  assign sda_f    = pin_f[3];
  assign sel_pins = pin_f[2:0];

  // previous filtered levels for edge finding; idle bus is high
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      // R5 idle levels high
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise  = scl_f & ~scl_q;
  assign scl_fall  = ~scl_f & scl_q;
  // R1 start detect
  assign bus_start = scl_f & scl_q & sda_q & ~sda_f;
  // R3 stop detect
  assign bus_stop  = scl_f & scl_q & ~sda_q & sda_f;

  // ========================================================================
  // bus sequencer

  tws_state_type state;
  logic [2:0]    bit_cnt;
  logic          byte_full;
  logic [7:0]    rx_shift;
  logic [7:0]    tx_shift;
  logic          first_byte;
  logic          rd_lo;
  logic          host_ack;
  logic          read_pulse;
  tws_sel_type   selector;
  logic [7:0]    config_reg;
  logic [15:0]   setpoint;
  logic [15:0]   hyst;
  logic [7:0]    next_tx;
  logic          wr_byte_end;
  logic          fifo_in_ready;

  // next byte to send, picked from the live register set
  assign next_tx = reg_byte(selector, rd_lo, i_temperature, config_reg, hyst, setpoint);

  // a received data byte ends at the fall after its eighth bit
  assign wr_byte_end = (state == TWS_WDATA) & scl_fall & byte_full;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state      <= TWS_IDLE;
      bit_cnt    <= `TWS_BIT_FIRST;
      byte_full  <= 1'b0;
      rx_shift   <= 8'h00;
      tx_shift   <= 8'h00;
      first_byte <= 1'b0;
      rd_lo      <= 1'b0;
      host_ack   <= 1'b0;
      o_sda_oe   <= 1'b0;
      read_pulse <= 1'b0;
    end else begin
      read_pulse <= 1'b0;
      if (bus_stop) begin
        // R3 stop releases the bus
        state    <= TWS_IDLE;
        o_sda_oe <= 1'b0;
      end else if (bus_start) begin
        // R1 start or repeated start
        state      <= TWS_ADDR;
        bit_cnt    <= `TWS_BIT_FIRST;
        byte_full  <= 1'b0;
        first_byte <= 1'b1;
        rd_lo      <= 1'b0; // every read access starts at the high byte
        o_sda_oe   <= 1'b0;
      end else begin
        case (state)
          // R2 silent until start
          TWS_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          TWS_ADDR, TWS_WDATA: begin
            if (scl_rise) begin
              // R7 shift in msb first
              rx_shift  <= {rx_shift[6:0], sda_f};
              bit_cnt   <= bit_cnt + 1'b1;
              byte_full <= (bit_cnt == `TWS_BIT_LAST);
            end else if (scl_fall && byte_full) begin
              byte_full <= 1'b0;
              bit_cnt   <= `TWS_BIT_FIRST;
              if (state == TWS_ADDR) begin
                if (addr_match(rx_shift, sel_pins)) begin
                  // R12 pull low for the ninth clock
                  state    <= TWS_ADDR_ACK;
                  o_sda_oe <= 1'b1;
                end else begin
                  // R22 mismatch stays released
                  state <= TWS_IGNORE;
                end
              end else if (fifo_in_ready) begin
                // R14 ack once the byte is stored
                state      <= TWS_WACK;
                o_sda_oe   <= 1'b1;
                first_byte <= 1'b0;
              end else begin
                // no room: refuse the byte and drop out
                state <= TWS_IGNORE;
              end
            end
          end
          TWS_ADDR_ACK: begin
            if (scl_fall) begin
              // R11 eighth bit picks direction
              if (rx_shift[0]) begin
                // R13 host clocks read data next
                state      <= TWS_RDATA;
                tx_shift   <= next_tx;
                o_sda_oe   <= ~next_tx[7];
                rd_lo      <= 1'b1;
                read_pulse <= 1'b1;
              end else begin
                state    <= TWS_WDATA;
                o_sda_oe <= 1'b0;
              end
            end
          end
          TWS_WACK: begin
            if (scl_fall) begin
              state    <= TWS_WDATA;
              o_sda_oe <= 1'b0;
            end
          end
          TWS_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == `TWS_BIT_LAST) begin
                // release for the host acknowledge clock
                state    <= TWS_RACK;
                bit_cnt  <= `TWS_BIT_FIRST;
                o_sda_oe <= 1'b0;
              end else begin
                // R7 shift out msb first
                // R4 change only while scl low
                tx_shift <= {tx_shift[6:0], 1'b0};
                o_sda_oe <= ~tx_shift[6];
                bit_cnt  <= bit_cnt + 1'b1;
              end
            end
          end
          TWS_RACK: begin
            if (scl_rise) begin
              host_ack <= ~sda_f;
            end else if (scl_fall) begin
              if (host_ack) begin
                state    <= TWS_RDATA;
                tx_shift <= next_tx;
                o_sda_oe <= ~next_tx[7];
                rd_lo    <= ~rd_lo;
              end else begin
                state <= TWS_IGNORE;
              end
            end
          end
          // R22 ignore until next start
          TWS_IGNORE: begin
            o_sda_oe <= 1'b0;
          end
          default: begin
            state    <= TWS_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // R6 open drain data pin only ever pulls low; scl is never driven
  assign o_sda_o = 1'b0;

  // ========================================================================
  // write buffer: bytes wait here until the register writer may take them

  logic [`TWS_FIFO_WIDTH-1:0] fifo_out_data;
  logic                       fifo_out_valid;
  logic                       fifo_out_ready;

  // writer stalls while the sensor core holds its registers
  assign fifo_out_ready = ~i_write_hold;

  tws_fifo #(
    .WIDTH (`TWS_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (wr_byte_end),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   ({first_byte, rx_shift}),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_data)
  );

  // ========================================================================
  // register writer

  logic wr_lo;
  logic pop;

  assign pop = fifo_out_valid & fifo_out_ready;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      selector        <= `TWS_RST_SEL;
      config_reg      <= `TWS_RST_CONFIG;
      setpoint        <= `TWS_RST_SETPOINT;
      hyst            <= `TWS_RST_HYST;
      wr_lo           <= 1'b0;
      o_reg_write     <= 1'b0;
      o_reg_write_sel <= `TWS_RST_SEL;
    end else begin
      o_reg_write <= 1'b0;
      if (pop) begin
        if (fifo_out_data[`TWS_FIFO_PTR_BIT]) begin
          // R16 selector keeps only the low two bits
          // R21 first byte loads the selector
          selector <= fifo_out_data[1:0];
          wr_lo    <= 1'b0;
        end else begin
          o_reg_write     <= (selector != `TWS_SEL_TEMP);
          o_reg_write_sel <= selector;
          // R21 later bytes, high byte first
          wr_lo <= ~wr_lo;
          case (selector)
            // R18 config is writable
            `TWS_SEL_CONFIG: config_reg <= fifo_out_data[7:0];
            // R19 sixteen-bit thresholds
            `TWS_SEL_HYST: begin
              if (wr_lo) hyst[7:0]  <= fifo_out_data[7:0];
              else       hyst[15:8] <= fifo_out_data[7:0];
            end
            `TWS_SEL_SETPOINT: begin
              if (wr_lo) setpoint[7:0]  <= fifo_out_data[7:0];
              else       setpoint[15:8] <= fifo_out_data[7:0];
            end
            // temperature is read only; writes fall away
            default: wr_lo <= ~wr_lo;
          endcase
        end
      end
    end
  end

  assign o_config               = config_reg;
  assign o_setpoint             = setpoint;
  assign o_hysteresis_threshold = hyst;
  assign o_reg_read             = read_pulse;

  // ========================================================================
  // alert pin: comparator follows the trip level, interrupt mode latches

  logic trip_q;
  logic shdn_q;
  logic alert_latch;
  logic alert_active;
  logic int_mode;

  assign int_mode     = config_reg[`TWS_CFG_INTMODE];
  assign alert_active = int_mode ? alert_latch : i_alert_trip;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      trip_q      <= 1'b0;
      shdn_q      <= 1'b0;
      alert_latch <= 1'b0;
    end else begin
      trip_q <= i_alert_trip;
      shdn_q <= config_reg[`TWS_CFG_SHUTDOWN];
      // new trip wins over a clear in the same cycle
      if (int_mode && i_alert_trip && !trip_q) begin
        alert_latch <= 1'b1;
      // R20 any read clears interrupt
      end else if (read_pulse || !int_mode ||
                   (config_reg[`TWS_CFG_SHUTDOWN] && !shdn_q)) begin
        alert_latch <= 1'b0;
      end
    end
  end

  // open drain: pull low when the active level is low, or when idle and high
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_alert_output_oe <= 1'b0;
    end else begin
      o_alert_output_oe <= alert_active ^ config_reg[`TWS_CFG_POLARITY];
    end
  end

  assign o_alert_output_o = 1'b0;

endmodule : tws_slave_port
`default_nettype wire

// ---- core/tws_cfg.svh ----
// constants of the two-wire sensor slave port
//
// Operation
// R1: sda falling while scl high is a start; it begins a transfer.
// R2: port watches both lines and stays silent until a start is seen.
// R3: sda rising while scl high is a stop; it ends the transfer.
// R4: sda must hold still while scl is high; it changes only when low.
// R5: idle bus keeps both sda and scl high.
// R6: host is master and makes every clock; port never drives scl.
// R7: every byte, address or data, moves most significant bit first.
// R8: access is start, address byte, one or more data bytes, stop.
// R9: accept only addresses whose top four bits equal the fixed prefix.
// R10: acknowledge only when low three address bits match the select pins.
// R11: eighth address bit: one asks for a read, zero for a write.
// R12: host releases sda after eight bits; port pulls it low on ninth clock.
// R13: after address ack host sends write data or clocks out read data.
// R14: acknowledge each written data byte once it is taken into storage.
// R15: transmitter ends every exchange with a stop condition.
// R16: selector is eight bits write only; low two bits pick the register.
// R17: selector 00 temperature, 01 configuration, 10 hysteresis, 11 setpoint.
// R18: configuration register is eight bits, readable and writable.
// R19: temperature, setpoint, hysteresis are 16-bit two's complement half degrees.
// R20: in interrupt mode any register read returns the alert to inactive.
// R21: first written byte loads selector; later bytes fill it, high byte first.
// R22: on address mismatch leave sda released and ignore bus until next start.
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// ==========================================================================
// bus address and bit counting
`define TWS_ADDR_PREFIX   4'h9
`define TWS_BIT_LAST      3'h7
`define TWS_BIT_FIRST     3'h0
`define TWS_PIN_IDLE      5'h1F

// ==========================================================================
// selector codes and configuration fields
`define TWS_SEL_TEMP      2'h0
`define TWS_SEL_CONFIG    2'h1
`define TWS_SEL_HYST      2'h2
`define TWS_SEL_SETPOINT  2'h3
`define TWS_CFG_SHUTDOWN  0
`define TWS_CFG_INTMODE   1
`define TWS_CFG_POLARITY  2

// ==========================================================================
// reset values
`define TWS_RST_CONFIG    8'h00
`define TWS_RST_SETPOINT  16'h0000
`define TWS_RST_HYST      16'h0000
`define TWS_RST_SEL       2'h0

// ==========================================================================
// write buffer shape: pointer flag above one data byte
`define TWS_FIFO_DEPTH    32
`define TWS_FIFO_WIDTH    9
`define TWS_FIFO_PTR_BIT  8

`endif

// ---- core/tws_pkg.sv ----
// types shared by the two-wire sensor slave port
package tws_pkg;

  // ========================================================================
  // bus sequencer states
  typedef enum logic [2:0] {
    TWS_IDLE,
    TWS_ADDR,
    TWS_ADDR_ACK,
    TWS_WDATA,
    TWS_WACK,
    TWS_RDATA,
    TWS_RACK,
    TWS_IGNORE
  } tws_state_type;

  typedef logic [1:0] tws_sel_type;

endpackage : tws_pkg

// ---- core/tws_fifo.sv ----
// synchronous fifo between the bus receiver and the register writer
`timescale 1ns/1ps
`default_nettype none
module tws_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);

  // ========================================================================
  // elaboration check: pointers wrap only on a power of two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("tws_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // honest flags straight from the occupancy count
  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_data  = mem[rd_ptr];

  // ========================================================================
  // storage array, no reset needed on data
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // pointers and count
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

endmodule : tws_fifo
`default_nettype wire

// ---- verif/tws_slave_port_sva.sv ----
// concurrent checks on the ports of the two-wire sensor slave port
`timescale 1ns/1ps
`default_nettype none
module tws_slave_port_sva (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_scl,
  input wire logic        i_alert_trip,
  input wire logic        o_sda_o,
  input wire logic        o_sda_oe,
  input wire logic        o_alert_output_o,
  input wire logic        o_alert_output_oe,
  input wire logic [7:0]  o_config,
  input wire logic [15:0] o_setpoint,
  input wire logic [15:0] o_hysteresis_threshold,
  input wire logic        o_reg_write,
  input wire logic [1:0]  o_reg_write_sel,
  input wire logic        o_reg_read
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // ==========================================================================
  // interrupt latch clear: a read with trip low, then the pin lets go
  sequence s_read_clear;
    o_config[1] && !o_config[2] && o_reg_read && !i_alert_trip;
  endsequence
  sequence s_released;
    ##[1:3] !o_alert_output_oe;
  endsequence

  // ==========================================================================
  // pin drive and data line timing
  pins_open_drain_a: assert property (!o_sda_o && !o_alert_output_o)
    else $error("open drain value not zero");
  sda_low_clk_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data drive changed while clock high");
  ack_hold_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*4])
    else $error("data drive too short");
  no_temp_wr_a: assert property (o_reg_write |-> o_reg_write_sel != 2'h0)
    else $error("write pulse for temperature");
  // a register changes only with a write pulse of its own selector, same edge
  cfg_wr_a: assert property ($changed(o_config) |-> o_reg_write && o_reg_write_sel == 2'h1)
    else $error("config changed without write");
  setp_wr_a: assert property ($changed(o_setpoint) |-> o_reg_write && o_reg_write_sel == 2'h3)
    else $error("setpoint changed without write");
  hyst_wr_a: assert property ($changed(o_hysteresis_threshold) |-> o_reg_write && o_reg_write_sel == 2'h2)
    else $error("hysteresis changed without write");
  read_pulse_a: assert property (o_reg_read |-> !i_scl ##1 !o_reg_read)
    else $error("read pulse malformed");
  alert_cmp_a: assert property ((!o_config[1] && $stable(o_config))
    |-> o_alert_output_oe == ($past(i_alert_trip) ^ o_config[2]))
    else $error("comparator alert wrong");
  alert_clr_a: assert property (s_read_clear |-> s_released)
    else $error("alert not cleared by read");
endmodule : tws_slave_port_sva

bind tws_slave_port tws_slave_port_sva u_sva (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_alert_trip(i_alert_trip),
  .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_alert_output_o(o_alert_output_o),
  .o_alert_output_oe(o_alert_output_oe), .o_config(o_config), .o_setpoint(o_setpoint),
  .o_hysteresis_threshold(o_hysteresis_threshold), .o_reg_write(o_reg_write),
  .o_reg_write_sel(o_reg_write_sel), .o_reg_read(o_reg_read)
);
`default_nettype wire

// ---- verif/tws_host_model.sv ----
// bus master model driving clock and data of the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module tws_host_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // all moves land just after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  // host clocks each bit, data moves only while low
  task automatic bit_io(input logic b, output logic r);
    o_scl = 1'b0;
    tick(1);
    o_sda_low = !b;
    tick(5);
    o_scl = 1'b1;
    tick(1);
    r = i_sda;
    tick(1);
  endtask : bit_io

  task automatic start();
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
    tick(4);
    o_sda_low = 1'b1;
    tick(4);
  endtask : start

  task automatic stop();
    o_scl = 1'b0;
    tick(1);
    o_sda_low = 1'b1;
    tick(5);
    o_scl = 1'b1;
    tick(3);
    o_sda_low = 1'b0;
    tick(4);
  endtask : stop

  // byte out, ninth clock with data released
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack);
  endtask : send

  // byte in, then host ack or nack on the last
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : recv
endmodule : tws_host_model
`default_nettype wire

// ---- verif/tb_tws_slave_port.sv ----
// self-checking testbench of the two-wire sensor slave port
`timescale 1ns/1ps
`default_nettype none
module tb_tws_slave_port;
  typedef struct {
    logic [1:0]  sel;
    logic [15:0] wdat;
    logic [15:0] exp;
  } tws_row_type;
  logic        clk, rstn, trip, hold, sda, scl, sda_low, sda_o, sda_oe, al_o, al_oe, wr, rd, a;
  logic [2:0]  pins;
  logic [1:0]  wr_sel;
  logic [7:0]  cfg;
  logic [15:0] temp, setp, hyst, got;
  int          errors, check_count, cycles;
  tws_row_type rows [4] = '{'{2'h3, 16'h1234, 16'h1234}, '{2'h2, 16'hABCD, 16'hABCD},
                            '{2'h1, 16'h0002, 16'h0002}, '{2'h0, 16'h5555, 16'h1F40}};

  // wired-and data line with pull-up
  assign sda = !(sda_low || (sda_oe && !sda_o));

  tws_host_model host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  // small fifo so the full case is cheap to reach
  tws_slave_port #(.FIFO_DEPTH(4)) DUT (
    .i_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_addr_select_hi(pins[2]), .i_addr_select_mid(pins[1]), .i_addr_select_lo(pins[0]),
    .i_temperature(temp), .i_alert_trip(trip), .i_write_hold(hold),
    .o_alert_output_o(al_o), .o_alert_output_oe(al_oe), .o_config(cfg), .o_setpoint(setp),
    .o_hysteresis_threshold(hyst), .o_reg_write(wr), .o_reg_write_sel(wr_sel), .o_reg_read(rd));

  // ==========================================================================
  // clock and hang guard
  initial clk = 1'b0;
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles > 12000) begin
      errors++;
      end_sim();
    end
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // selector byte then data bytes, each expected to be acked
  task automatic acc_write(input logic [1:0] sel, input logic [15:0] w);
    host.start();
    host.send({4'h9, pins, 1'b0}, a);
    check(a, 1'b0);
    host.send({6'h00, sel}, a);
    check(a, 1'b0);
    if (sel != 2'h1) begin
      host.send(w[15:8], a);
      check(a, 1'b0);
    end
    host.send(w[7:0], a);
    check(a, 1'b0);
    host.stop();
  endtask : acc_write

  // read one byte for config, two bytes high first otherwise
  task automatic acc_read(input logic one, output logic [15:0] v);
    host.start();
    host.send({4'h9, pins, 1'b1}, a);
    check(a, 1'b0);
    v = 16'h0000;
    if (one) begin
      host.recv(1'b1, v[7:0]);
    end else begin
      host.recv(1'b0, v[15:8]);
      host.recv(1'b1, v[7:0]);
    end
    host.stop();
  endtask : acc_read

  // ==========================================================================
  // main sequence
  initial begin
    rstn = 1'b0;
    trip = 1'b0;
    hold = 1'b0;
    pins = 3'h5;
    temp = 16'h1F40;
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    host.tick(6);
    check({cfg, setp, hyst}, 40'h0);
    check(sda_oe, 1'b0);
    // comparator mode follows the trip level
    trip = 1'b1;
    host.tick(3);
    check(al_oe, 1'b1);
    trip = 1'b0;
    host.tick(3);
    check(al_oe, 1'b0);
    // register rows: write through the selector, read back high byte first
    for (int i = 0; i < 4; i++) begin
      pins = 3'(i + 5);
      acc_write(rows[i].sel, rows[i].wdat);
      acc_read(rows[i].sel == 2'h1, got);
      check(got, rows[i].exp);
    end
    check({cfg, setp, hyst}, {8'h02, 16'h1234, 16'hABCD});
    // interrupt mode: latch holds until a read
    trip = 1'b1;
    host.tick(2);
    trip = 1'b0;
    host.tick(3);
    check(al_oe, 1'b1);
    // live temperature word is read, high byte first
    temp = 16'hFF38;
    acc_read(1'b0, got);
    check(al_oe, 1'b0);
    check(got, 16'hFF38);
    // wrong prefix and wrong pins: no ack, later bytes ignored
    for (int i = 0; i < 2; i++) begin
      host.start();
      host.send(i == 0 ? {4'hA, pins, 1'b0} : {4'h9, ~pins, 1'b0}, a);
      check(a, 1'b1);
      host.send(8'h01, a);
      check(a, 1'b1);
      host.stop();
    end
    // stalled writer: fifo fills, fifth byte refused, then drains
    hold = 1'b1;
    host.start();
    host.send({4'h9, pins, 1'b0}, a);
    host.send(8'h01, a);
    host.send(8'h00, a);
    host.send(8'h04, a);
    host.send(8'h18, a);
    check(a, 1'b0);
    host.send(8'h1C, a);
    check(a, 1'b1);
    host.stop();
    check(cfg, 8'h02);
    hold = 1'b0;
    host.tick(10);
    check(cfg, 8'h18);
    // mid-run reset returns registers and data drive to idle values
    rstn = 1'b0;
    host.tick(2);
    check({cfg, setp, hyst}, 40'h0);
    check({sda_oe, al_oe}, 2'h0);
    rstn = 1'b1;
    host.tick(6);
    check({sda_oe, al_oe}, 2'h0);
    end_sim();
  end
endmodule : tb_tws_slave_port
`default_nettype wire
